// *** dv/acwpc_host.sv ***
// Purpose: host side of the four-wire serial link
// Assumes: shift clock half period 32 ns, idles low between frames
// Notes: no deliberate faults
`timescale 1ns/1ps
module acwpc_host
(
	output logic      shift_clk,
	output logic      serial_in,
	output logic      conversion_trigger,
	input  wire logic serial_out
);
	int n_fall;
	initial
	begin
		shift_clk = 1'b0;
		serial_in = 1'b0;
		conversion_trigger = 1'b0;
		n_fall = 0;
	end
	// ==========
	// one frame: trigger rise, then 16 shift clocks
	task automatic xfer(input logic [7:0] w, output logic [15:0] res);
		int i;
		n_fall = 0;
		conversion_trigger = 1'b1;
		#203;
		for (i = 0; i < 16; i++)
		begin
			serial_in = (i < 8) ? w[7 - i] : ~serial_in;
			// dropped mid-frame so it stays still once deep shutdown starts
			if (i == 4)
				conversion_trigger = 1'b0;
			#32 shift_clk = 1'b1;
			res = {res[14:0], serial_out};
			#32 shift_clk = 1'b0;
			n_fall = i + 1;
		end
		serial_in = ~serial_in;
	endtask
endmodule

// *** dv/acwpc_properties.sv ***
// Purpose: port assertions for the converter configuration block
// Assumes: single core_clk domain
// Notes: bound to acwpc_core below
`timescale 1ns/1ps
module acwpc_properties
(
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       conversion_active_b,
	input wire logic [1:0] power_mode,
	input wire logic       sample_hold,
	input wire logic [8:0] mux_pos_sel,
	input wire logic [8:0] mux_neg_sel,
	input wire logic       s_awvalid,
	input wire logic       s_awready,
	input wire logic       s_bvalid,
	input wire logic       s_bready,
	input wire logic       s_arvalid,
	input wire logic       s_arready,
	input wire logic       s_rvalid
);
	import acwpc_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// sequences
	sequence s_conv_start;
		$fell(conversion_active_b);
	endsequence
	sequence s_aw_taken;
		s_awvalid && s_awready;
	endsequence
	// ==========
	// properties
	property p_conv_len;
		s_conv_start |-> !conversion_active_b[*8];
	endproperty
	property p_hold;
		sample_hold |-> ##[0:2] !conversion_active_b;
	endproperty
	property p_pwr_code;
		power_mode inside {ACWPC_PWR_ON, ACWPC_PWR_LIGHT, ACWPC_PWR_DEEP};
	endproperty
	property p_light_entry;
		$changed(power_mode) && power_mode == ACWPC_PWR_LIGHT |-> conversion_active_b;
	endproperty
	property p_mux;
		$onehot0(mux_pos_sel) && $onehot0(mux_neg_sel) && (mux_pos_sel & mux_neg_sel) == 9'h000;
	endproperty
	property p_conv_mux;
		s_conv_start |-> ##[0:2] (mux_pos_sel != 9'h000 && mux_neg_sel != 9'h000);
	endproperty
	property p_b_answer;
		s_aw_taken |-> ##[1:4] s_bvalid;
	endproperty
	property p_b_hold;
		s_bvalid && !s_bready |=> s_bvalid;
	endproperty
	property p_r_answer;
		s_arvalid && s_arready |=> s_rvalid;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion ended early");
	a_hold: assert property (p_hold) else $error("hold pulse without conversion");
	a_pwr_code: assert property (p_pwr_code) else $error("bad power code");
	a_light_entry: assert property (p_light_entry) else $error("light entry while busy");
	a_mux: assert property (p_mux) else $error("mux select not one-hot");
	a_conv_mux: assert property (p_conv_mux) else $error("conversion without mux");
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	a_r_answer: assert property (p_r_answer) else $error("read response late");
endmodule

bind acwpc_core acwpc_properties u_props
(
	.core_clk(core_clk), .rst_b(rst_b), .conversion_active_b(conversion_active_b),
	.power_mode(power_mode), .sample_hold(sample_hold), .mux_pos_sel(mux_pos_sel),
	.mux_neg_sel(mux_neg_sel), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_bvalid(s_bvalid),
	.s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid)
);

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the converter configuration block
// Assumes: host model on the link, register access over AXI4-Lite
// Notes: NEXT register stands in for the converter output
`timescale 1ns/1ps
module tb_top;
	import acwpc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        shift_clk, serial_in, conversion_trigger, serial_out, conversion_active_b, sample_hold;
	logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, w, prev;
	logic [31:0] s_wdata = 32'h0000_0000, s_rdata, d;
	logic [3:0]  s_wstrb = 4'hF;
	logic [1:0]  s_bresp, s_rresp, power_mode, r;
	logic [8:0]  mux_pos_sel, mux_neg_sel;
	logic [15:0] res;
	int          n_errors = 0, compares = 0, i;

	always #4 core_clk = ~core_clk;

	acwpc_host u_host (.shift_clk(shift_clk), .serial_in(serial_in),
		.conversion_trigger(conversion_trigger), .serial_out(serial_out));

	acwpc_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .shift_clk(shift_clk), .serial_in(serial_in),
		.conversion_trigger(conversion_trigger), .serial_out(serial_out),
		.conversion_active_b(conversion_active_b), .power_mode(power_mode), .sample_hold(sample_hold),
		.mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

	// ==========
	// checks and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge core_clk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
			n++;
		end
		while (s_bvalid !== 1'b1 && n < 64);
		if (s_bvalid !== 1'b1)
			n_errors++;
		rs = s_bresp;
		s_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge core_clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			if (s_arready)
				s_arvalid <= 1'b0;
			n++;
		end
		while (s_rvalid !== 1'b1 && n < 64);
		if (s_rvalid !== 1'b1)
			n_errors++;
		v = s_rdata;
		rs = s_rresp;
		s_rready <= 1'b0;
	endtask

	// bounded: a conversion still busy after 2000 cycles is counted as an error, not a hang
	task automatic idle();
		int n;
		n = 0;
		while (conversion_active_b !== 1'b1 && n < 2000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (conversion_active_b !== 1'b1)
			n_errors++;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic pchk(input int k, input logic [1:0] e);
		wait (u_host.n_fall == k);
		repeat (5) @(posedge core_clk);
		chk(power_mode, e);
	endtask

	task automatic frame(input logic [7:0] fw, input int k, input logic [1:0] e0, input logic [1:0] e1);
		fork
			u_host.xfer(fw, res);
			begin
				pchk(k - 1, e0);
				pchk(k, e1);
			end
		join
	endtask

	function automatic logic [8:0] msel(input logic [7:0] cw, input logic ng);
		if (cw[7])
			return ng ? 9'h100 : 9'h001 << {cw[5:4], cw[6]};
		return 9'h001 << ({cw[5:4], 1'b0} + {2'b00, cw[6] ^ ng});
	endfunction

	task automatic close_out();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========
	// tests
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(ACWPC_ADDR_CTRL, d, r);
		// control register is write-only on the bus and reads back as zero
		chk(d, 32'h0000_0000);
		rd(8'h20, d, r);
		chk(d, 32'h0000_0000);
		chk(r, ACWPC_RESP_SLVERR);
		wr(8'h20, 32'h0000_0000, r);
		chk(r, ACWPC_RESP_SLVERR);
		prev = ACWPC_CFG_RESET;
		for (i = 0; i <= 16; i++)
		begin
			w = {i[3:0], ~i[1:0], 2'b00};
			wr(ACWPC_ADDR_NEXT, 32'h0000_5A00 + i, r);
			u_host.xfer(w, res);
			if (i > 0)
				chk(res, 32'h0000_5A00 + i - 1);
			chk(mux_pos_sel, msel(prev, 1'b0));
			chk(mux_neg_sel, msel(prev, 1'b1));
			chk(power_mode, ACWPC_PWR_ON);
			rd(ACWPC_ADDR_CONFIG, d, r);
			chk(d[7:0], w);
			prev = w;
			idle();
		end
		// a word configures the conversion started by the next trigger
		u_host.xfer(8'h02, res);
		idle();
		chk(power_mode, ACWPC_PWR_ON);
		u_host.xfer(8'h02, res);
		chk(power_mode, ACWPC_PWR_ON);
		idle();
		chk(power_mode, ACWPC_PWR_LIGHT);
		frame(8'h02, 2, ACWPC_PWR_LIGHT, ACWPC_PWR_ON);
		idle();
		chk(power_mode, ACWPC_PWR_LIGHT);
		frame(8'h03, 16, ACWPC_PWR_ON, ACWPC_PWR_DEEP);
		rd(ACWPC_ADDR_STATUS, d, r);
		chk(d[1:0], ACWPC_PWR_DEEP);
		idle();
		frame(8'h80, 16, ACWPC_PWR_DEEP, ACWPC_PWR_ON);
		// recovery interval shortened to a few cycles in the bench
		idle();
		chk(power_mode, ACWPC_PWR_ON);
		close_out();
	end

	initial
	begin
		#400_000;
		n_errors++;
		close_out();
	end
endmodule

// *** hw/acwpc_axil.sv ***
// Purpose: AXI4-Lite register slave for the configuration block
// Assumes: one write and one read at most under way
// Notes: unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/1ps
module acwpc_axil
(
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire logic [7:0]              s_awaddr,
	input  wire logic                    s_awvalid,
	input  wire logic [31:0]             s_wdata,
	input  wire logic [3:0]              s_wstrb,
	input  wire logic                    s_wvalid,
	input  wire logic                    s_bready,
	input  wire logic [7:0]              s_araddr,
	input  wire logic                    s_arvalid,
	input  wire logic                    s_rready,
	input  wire logic [31:0]             status_word,
	input  wire logic [31:0]             config_word,
	input  wire logic [31:0]             result_word,
	input  wire logic [31:0]             next_word,
	output acwpc_pkg::acwpc_bus_t         bus,
	output logic                         wr_pulse,
	output logic [7:0]                   wr_addr,
	output logic [31:0]                  wr_data,
	output logic [3:0]                   wr_strb
);
	import acwpc_pkg::*;

	acwpc_bus_t bus_reg;
	acwpc_bus_t bus_next;

	function automatic logic mapped(input logic [7:0] a);
		if (a == ACWPC_ADDR_CTRL)
			return 1'b1;
		else if (a == ACWPC_ADDR_STATUS)
			return 1'b1;
		else if (a == ACWPC_ADDR_CONFIG)
			return 1'b1;
		else if (a == ACWPC_ADDR_RESULT)
			return 1'b1;
		else if (a == ACWPC_ADDR_NEXT)
			return 1'b1;
		else
			return 1'b0;
	endfunction

	always_comb
	begin
		bus_next = bus_reg;
		bus_next.awready = 1'b0;
		bus_next.wready  = 1'b0;
		bus_next.arready = 1'b0;
		if (s_awvalid && !bus_reg.aw_seen && !bus_reg.awready && !bus_reg.bvalid)
			bus_next.awready = 1'b1;
		if (s_awvalid && bus_reg.awready)
		begin
			bus_next.aw_seen = 1'b1;
			bus_next.aw_addr = s_awaddr;
		end
		if (s_wvalid && !bus_reg.w_seen && !bus_reg.wready && !bus_reg.bvalid)
			bus_next.wready = 1'b1;
		if (s_wvalid && bus_reg.wready)
		begin
			bus_next.w_seen = 1'b1;
			bus_next.wdata  = s_wdata;
			bus_next.wstrb  = s_wstrb;
		end
		if (bus_reg.aw_seen && bus_reg.w_seen)
		begin
			bus_next.aw_seen = 1'b0;
			bus_next.w_seen  = 1'b0;
			bus_next.bvalid  = 1'b1;
			bus_next.bresp   = mapped(bus_reg.aw_addr) ? ACWPC_RESP_OKAY : ACWPC_RESP_SLVERR;
		end
		if (bus_reg.bvalid && s_bready)
			bus_next.bvalid = 1'b0;
		if (s_arvalid && !bus_reg.arready && !bus_reg.rvalid)
			bus_next.arready = 1'b1;
		if (s_arvalid && bus_reg.arready)
		begin
			bus_next.rvalid = 1'b1;
			bus_next.rresp  = mapped(s_araddr) ? ACWPC_RESP_OKAY : ACWPC_RESP_SLVERR;
			if (s_araddr == ACWPC_ADDR_STATUS)
				bus_next.rdata = status_word;
			else if (s_araddr == ACWPC_ADDR_CONFIG)
				bus_next.rdata = config_word;
			else if (s_araddr == ACWPC_ADDR_RESULT)
				bus_next.rdata = result_word;
			else if (s_araddr == ACWPC_ADDR_NEXT)
				bus_next.rdata = next_word;
			else
				bus_next.rdata = '0;
		end
		if (bus_reg.rvalid && s_rready)
			bus_next.rvalid = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			bus_reg <= '0;
		else
			bus_reg <= bus_next;
	end

	assign bus      = bus_reg;
	assign wr_pulse = bus_reg.aw_seen && bus_reg.w_seen;
	assign wr_addr  = bus_reg.aw_addr;
	assign wr_data  = bus_reg.wdata;
	assign wr_strb  = bus_reg.wstrb;
endmodule

// *** hw/acwpc_core.sv ***
// Purpose: serial configuration word capture, mux decode and power mode sequencing
// Assumes: link clock is slow against core_clk; all link inputs are synchronised here
// Notes: the conversion itself is modelled by a fixed busy interval
`timescale 1ns/1ps
// Overview of operation
// [R1] first four word bits set mux
// [R2] convert between table's plus and minus inputs
// [R3] differential: one adjacent pair, polarity selectable
// [R4] single-ended measures channel against common return
// [R5] both inputs sampled at one instant
// [R6] word bits five and six ignored
// [R7] light bit alone selects light shutdown
// [R8] deep bit wins over light bit
// [R9] light: shift out, convert, then power down
// [R10] light shutdown starts at conversion end
// [R11] light shutdown ends second clock's fall
// [R12] host sets light bit every word
// [R13] deep shutdown entered sixteenth clock's fall
// [R14] host keeps trigger steady in deep shutdown
// [R15] wake needs trigger rise, deep bit zero
// [R16] host waits recovery interval after wake
// [R17] capture eight bits, ignore rest
// [R18] shift out on fall, sample on rise
// [R19] result returned one transfer later
// [R20] select bits pick pair, polarity swaps
// [R21] word shifted msb first
module acwpc_core
(
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire logic                    shift_clk,
	input  wire logic                    serial_in,
	input  wire logic                    conversion_trigger,
	output logic                         serial_out,
	output logic                         conversion_active_b,
	output logic [1:0]                   power_mode,
	output logic                         sample_hold,
	output logic [8:0]                   mux_pos_sel,
	output logic [8:0]                   mux_neg_sel,
	input  wire logic [7:0]              s_awaddr,
	input  wire logic                    s_awvalid,
	output logic                         s_awready,
	input  wire logic [31:0]             s_wdata,
	input  wire logic [3:0]              s_wstrb,
	input  wire logic                    s_wvalid,
	output logic                         s_wready,
	output logic [1:0]                   s_bresp,
	output logic                         s_bvalid,
	input  wire logic                    s_bready,
	input  wire logic [7:0]              s_araddr,
	input  wire logic                    s_arvalid,
	output logic                         s_arready,
	output logic [31:0]                  s_rdata,
	output logic [1:0]                   s_rresp,
	output logic                         s_rvalid,
	input  wire logic                    s_rready
);
	import acwpc_pkg::*;

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [1:0]  sck_sync;
		logic [1:0]  sdi_sync;
		logic [1:0]  cnv_sync;
		logic        sck_d;
		logic        cnv_d;
		logic [4:0]  bit_cnt;
		logic [7:0]  shift_in;
		logic [15:0] shift_out;
		logic        out_bit;
		logic [7:0]  word;
		logic        word_ok;
		acwpc_cfg_t  cfg_pend;
		acwpc_cfg_t  cfg_act;
		logic [15:0] result;
		logic [15:0] next_result;
		logic        busy;
		logic [9:0]  conv_cnt;
		acwpc_pwr_t  pwr;
		logic        light_arm;
		logic        wake_armed;
		logic        hold;
		acwpc_mux_t  mux;
		logic        conv_en;
	} acwpc_state_t;

	acwpc_state_t st_reg;
	acwpc_state_t st_next;

	acwpc_bus_t  bus;
	logic        wr_pulse;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;

	function automatic acwpc_mux_t mux_of(input acwpc_cfg_t c);
		acwpc_mux_t m;
		logic [3:0] even;
		logic [3:0] odd;
		even = {1'b0, c.sel, 1'b0};
		odd  = {1'b0, c.sel, 1'b1};
		m.pos_sel = '0;
		m.neg_sel = '0;
		if (c.single)
		begin
			m.pos_sel[c.odd ? odd : even] = 1'b1; // [R4] [R20]
			m.neg_sel = ACWPC_COMMON_SEL; // [R4]
		end
		else
		begin
			m.pos_sel[c.odd ? odd : even] = 1'b1; // [R3] [R20]
			m.neg_sel[c.odd ? even : odd] = 1'b1; // [R3] [R2]
		end
		return m;
	endfunction

	wire sck_rise = st_reg.sck_sync[1] && !st_reg.sck_d;
	wire sck_fall = !st_reg.sck_sync[1] && st_reg.sck_d;
	wire cnv_rise = st_reg.cnv_sync[1] && !st_reg.cnv_d;

	// ==========================================================
	// sequencing
	always_comb
	begin
		st_next = st_reg;
		st_next.sck_sync = {st_reg.sck_sync[0], shift_clk};
		st_next.sdi_sync = {st_reg.sdi_sync[0], serial_in};
		st_next.cnv_sync = {st_reg.cnv_sync[0], conversion_trigger};
		st_next.sck_d = st_reg.sck_sync[1];
		st_next.cnv_d = st_reg.cnv_sync[1];
		st_next.hold  = 1'b0;
		if (sck_rise && st_reg.bit_cnt < ACWPC_CNT_WORD)
		begin
			st_next.shift_in = {st_reg.shift_in[6:0], st_reg.sdi_sync[1]}; // [R17] [R18] [R21]
			if (st_reg.bit_cnt == ACWPC_CNT_WORD - 5'h01)
			begin
				st_next.word     = {st_reg.shift_in[6:0], st_reg.sdi_sync[1]};
				st_next.cfg_pend = acwpc_decode({st_reg.shift_in[6:0], st_reg.sdi_sync[1]}); // [R1] [R6]
				st_next.word_ok  = 1'b1;
			end
		end
		if (sck_fall && st_reg.bit_cnt < ACWPC_CNT_LAST)
		begin
			st_next.bit_cnt   = st_reg.bit_cnt + 5'h01;
			st_next.out_bit   = st_reg.shift_out[15]; // [R18] [R19]
			st_next.shift_out = {st_reg.shift_out[14:0], 1'b0};
			if (st_reg.bit_cnt + 5'h01 == ACWPC_CNT_WAKE && st_reg.pwr == ACWPC_PWR_LIGHT)
				st_next.pwr = ACWPC_PWR_ON; // [R11]
			if (st_reg.bit_cnt + 5'h01 == ACWPC_CNT_LAST && st_reg.word_ok)
			begin
				if (st_reg.cfg_pend.deep)
					st_next.pwr = ACWPC_PWR_DEEP; // [R13] [R8]
				else if (st_reg.pwr == ACWPC_PWR_DEEP && st_reg.wake_armed)
				begin
					st_next.pwr        = ACWPC_PWR_ON; // [R15]
					st_next.wake_armed = 1'b0;
				end
			end
		end
		// a trigger while in deep shutdown arms the wake and starts no conversion
		// the wake trigger still opens a transfer, so the deep-bit-zero word can be taken
		if (cnv_rise && st_reg.pwr == ACWPC_PWR_DEEP)
		begin
			st_next.wake_armed = 1'b1; // [R15]
			st_next.bit_cnt    = '0;
			st_next.word_ok    = 1'b0;
			st_next.out_bit    = st_reg.result[15];
			st_next.shift_out  = {st_reg.result[14:0], 1'b0};
		end
		else if (cnv_rise && !st_reg.busy && st_reg.conv_en)
		begin
			st_next.busy      = 1'b1;
			st_next.hold      = 1'b1; // [R5]
			st_next.conv_cnt  = ACWPC_CONV_CNT;
			st_next.cfg_act   = st_reg.cfg_pend;
			st_next.mux       = mux_of(st_reg.cfg_pend); // [R1] [R2]
			st_next.light_arm = (acwpc_pwr_of(st_reg.cfg_pend) == ACWPC_PWR_LIGHT); // [R7] [R9]
			st_next.bit_cnt   = '0;
			st_next.word_ok   = 1'b0;
			st_next.out_bit   = st_reg.result[15]; // [R19]
			st_next.shift_out = {st_reg.result[14:0], 1'b0};
		end
		if (st_reg.busy)
		begin
			if (st_reg.conv_cnt == '0)
			begin
				st_next.busy   = 1'b0;
				st_next.result = st_reg.next_result; // [R19]
				// deep shutdown requested meanwhile must not be undone by a late light entry
				if (st_reg.light_arm && st_next.pwr != ACWPC_PWR_DEEP)
					st_next.pwr = ACWPC_PWR_LIGHT; // [R10] [R8]
				st_next.light_arm = 1'b0;
			end
			else
				st_next.conv_cnt = st_reg.conv_cnt - 10'h001;
		end
		if (wr_pulse && wr_addr == ACWPC_ADDR_CTRL && wr_strb[0])
			st_next.conv_en = wr_data[0];
		if (wr_pulse && wr_addr == ACWPC_ADDR_NEXT)
			st_next.next_result = wr_data[15:0];
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg          <= '0;
			st_reg.cfg_pend <= acwpc_decode(ACWPC_CFG_RESET);
			st_reg.cfg_act  <= acwpc_decode(ACWPC_CFG_RESET);
			st_reg.conv_en  <= 1'b1;
			st_reg.pwr      <= ACWPC_PWR_ON;
			st_reg.bit_cnt  <= ACWPC_CNT_LAST;
		end
		else
			st_reg <= st_next;
	end

	// ==========================================================
	// register bus
	acwpc_axil u_axil
	(
		.core_clk    (core_clk),
		.rst_b       (rst_b),
		.s_awaddr    (s_awaddr),
		.s_awvalid   (s_awvalid),
		.s_wdata     (s_wdata),
		.s_wstrb     (s_wstrb),
		.s_wvalid    (s_wvalid),
		.s_bready    (s_bready),
		.s_araddr    (s_araddr),
		.s_arvalid   (s_arvalid),
		.s_rready    (s_rready),
		.status_word ({24'h00_0000, st_reg.bit_cnt, st_reg.busy, st_reg.pwr}),
		.config_word ({16'h0000, st_reg.cfg_act, 2'b00, st_reg.word}),
		.result_word ({16'h0000, st_reg.result}),
		.next_word   ({16'h0000, st_reg.next_result}),
		.bus         (bus),
		.wr_pulse    (wr_pulse),
		.wr_addr     (wr_addr),
		.wr_data     (wr_data),
		.wr_strb     (wr_strb)
	);

	assign serial_out          = st_reg.out_bit;
	assign conversion_active_b = !st_reg.busy;
	assign power_mode          = st_reg.pwr;
	assign sample_hold         = st_reg.hold;
	assign mux_pos_sel         = st_reg.mux.pos_sel;
	assign mux_neg_sel         = st_reg.mux.neg_sel;
	assign s_awready           = bus.awready;
	assign s_wready            = bus.wready;
	assign s_bresp             = bus.bresp;
	assign s_bvalid            = bus.bvalid;
	assign s_arready           = bus.arready;
	assign s_rdata             = bus.rdata;
	assign s_rresp             = bus.rresp;
	assign s_rvalid            = bus.rvalid;
endmodule

// *** shared/acwpc_pkg.sv ***
// Purpose: shared constants and types for the converter configuration word and power control block
// Assumes: 125 MHz core clock, serial link sampled by the core clock
// Notes: register map is reached over an AXI4-Lite slave
package acwpc_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0]  ACWPC_ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ACWPC_ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ACWPC_ADDR_CONFIG = 8'h08;
	localparam logic [7:0]  ACWPC_ADDR_RESULT = 8'h0C;
	localparam logic [7:0]  ACWPC_ADDR_NEXT   = 8'h10;
	localparam logic [1:0]  ACWPC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  ACWPC_RESP_SLVERR = 2'h2;

	// ==========================================================
	// configuration word fields, msb first on the wire
	localparam int ACWPC_WORD_BITS   = 8;
	localparam int ACWPC_RES_BITS    = 16;
	localparam int ACWPC_BIT_SGL     = 7;
	localparam int ACWPC_BIT_ODD     = 6;
	localparam int ACWPC_BIT_SEL1    = 5;
	localparam int ACWPC_BIT_SEL0    = 4;
	localparam int ACWPC_BIT_LIGHT   = 1;
	localparam int ACWPC_BIT_DEEP    = 0;
	localparam logic [4:0] ACWPC_CNT_WORD  = 5'h08;
	localparam logic [4:0] ACWPC_CNT_WAKE  = 5'h02;
	localparam logic [4:0] ACWPC_CNT_LAST  = 5'h10;
	localparam logic [7:0] ACWPC_CFG_RESET = 8'h80;
	localparam logic [8:0] ACWPC_COMMON_SEL = 9'h100;

	// ==========================================================
	// timing
	localparam int ACWPC_CLK_MHZ       = 125;
	localparam int ACWPC_CONV_NS       = 4000;
	localparam int ACWPC_CONV_CYC      = (ACWPC_CONV_NS * ACWPC_CLK_MHZ + 999) / 1000;
	localparam logic [9:0] ACWPC_CONV_CNT = 10'(ACWPC_CONV_CYC);

	typedef enum logic [1:0]
	{
		ACWPC_PWR_ON    = 2'b00,
		ACWPC_PWR_LIGHT = 2'b01,
		ACWPC_PWR_DEEP  = 2'b11
	} acwpc_pwr_t;

	typedef struct packed
	{
		logic       single;
		logic       odd;
		logic [1:0] sel;
		logic       light;
		logic       deep;
	} acwpc_cfg_t;

	typedef struct packed
	{
		logic [8:0] pos_sel;
		logic [8:0] neg_sel;
	} acwpc_mux_t;

	typedef struct packed
	{
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        aw_seen;
		logic        w_seen;
		logic [7:0]  aw_addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} acwpc_bus_t;

	// ==========================================================
	// decode helpers
	function automatic acwpc_cfg_t acwpc_decode(input logic [7:0] w);
		acwpc_cfg_t c;
		c.single = w[ACWPC_BIT_SGL];
		c.odd    = w[ACWPC_BIT_ODD];
		c.sel    = {w[ACWPC_BIT_SEL1], w[ACWPC_BIT_SEL0]};
		c.light  = w[ACWPC_BIT_LIGHT];
		c.deep   = w[ACWPC_BIT_DEEP];
		return c;
	endfunction

	function automatic acwpc_pwr_t acwpc_pwr_of(input acwpc_cfg_t c);
		if (c.deep)
			return ACWPC_PWR_DEEP;
		else if (c.light)
			return ACWPC_PWR_LIGHT;
		else
			return ACWPC_PWR_ON;
	endfunction

endpackage
